// [ievt_pkg.sv]
// ============================================================
// shared constants of the internal event block
package ievt_pkg;

  localparam int NUM_CH = 5;
  localparam int NUM_SRC = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CODE_W = 6;
  localparam int OPT_W = 16;
  localparam int SP_W = 16;
  localparam int GRP_W = 4;

  // ============================================================
  // register map, byte addresses
  localparam logic [7:0] REG_TYPE_BASE = 8'h00;
  localparam logic [7:0] REG_OPT_BASE = 8'h04;
  localparam logic [7:0] REG_CH_STRIDE = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_IRQ_STAT = 8'h2c;
  localparam logic [7:0] REG_IRQ_CLR = 8'h30;
  localparam logic [7:0] REG_IRQ_EN = 8'h34;
  localparam logic [7:0] REG_SETPOINT = 8'h38;

  // ============================================================
  // field positions and reset values
  localparam int STAT_EVT_LSB = 0;
  localparam int STAT_STBY_LSB = 8;
  localparam int STAT_GRP_LSB = 16;
  localparam int IRQ_RISE_LSB = 0;
  localparam int IRQ_FALL_LSB = 8;
  localparam int DIG_POL_LSB = 0;
  localparam int DIG_STBY_LSB = 4;
  localparam int DIG_HALT_LSB = 8;
  localparam logic [CODE_W-1:0] TYPE_RST = 6'h00;
  localparam logic [OPT_W-1:0] OPT_RST = 16'h0000;
  localparam logic [NUM_CH-1:0] IRQ_EN_RST = 5'h00;

  // ============================================================
  // operation type codes
  localparam logic [CODE_W-1:0] CODE_NONE = 6'h00;
  localparam logic [CODE_W-1:0] CODE_LIMIT_LAST = 6'h0f;
  localparam logic [CODE_W-1:0] CODE_HEAT1_BURN = 6'h10;
  localparam logic [CODE_W-1:0] CODE_HEAT1_SHORT = 6'h11;
  localparam logic [CODE_W-1:0] CODE_HEAT2_BURN = 6'h12;
  localparam logic [CODE_W-1:0] CODE_HEAT2_SHORT = 6'h13;
  localparam logic [CODE_W-1:0] CODE_DIAG1 = 6'h14;
  localparam logic [CODE_W-1:0] CODE_DIAG2 = 6'h15;
  localparam logic [CODE_W-1:0] CODE_DIAG3 = 6'h16;
  localparam logic [CODE_W-1:0] CODE_ALARM = 6'h17;
  localparam logic [CODE_W-1:0] CODE_HALTED = 6'h18;
  localparam logic [CODE_W-1:0] CODE_MANUAL = 6'h19;
  localparam logic [CODE_W-1:0] CODE_INVALID_A = 6'h1a;
  localparam logic [CODE_W-1:0] CODE_AUTOTUNE = 6'h1b;
  localparam logic [CODE_W-1:0] CODE_RAMP = 6'h1c;
  localparam logic [CODE_W-1:0] CODE_DIRECT = 6'h1d;
  localparam logic [CODE_W-1:0] CODE_SELFTUNE = 6'h1e;
  localparam logic [CODE_W-1:0] CODE_INVALID_B = 6'h1f;
  localparam logic [CODE_W-1:0] CODE_TIMER = 6'h20;

  // limit sources, in code order 1..15 (three codes each)
  localparam int SRC_PV = 0;
  localparam int SRC_DEV = 1;
  localparam int SRC_DEV_FINAL = 2;
  localparam int SRC_SP = 3;
  localparam int SRC_MV = 4;

  // option digit values
  localparam logic [3:0] DIG_ZERO = 4'h0;
  localparam logic [3:0] DIG_ONE = 4'h1;
  localparam logic [3:0] DIG_TWO = 4'h2;

endpackage

// [ievt_qualify.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// standby qualification, halted forcing and polarity of one channel
module ievt_qualify
  import ievt_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, high
  input wire logic enable, // type code is 1..32
  input wire logic rawCond, // on condition before polarity
  input wire logic [3:0] polDigit, // first option digit
  input wire logic [3:0] stbyDigit, // second option digit
  input wire logic [3:0] haltDigit, // third option digit
  input wire logic halted, // halted mode active
  input wire logic haltRelease, // halted to running, one cycle
  input wire logic spChanged, // effective setpoint changed, one cycle
  output logic eventOut, // final event output
  output logic standbyActive // suppression in force
);

  logic standby_r;
  logic stbyOn;
  logic stbyResp;
  logic arm;
  logic qualified;

  assign stbyOn = (stbyDigit == DIG_ONE) || (stbyDigit == DIG_TWO);
  assign stbyResp = (stbyDigit == DIG_TWO);
  assign arm = haltRelease || (stbyResp && spChanged);

  // ============================================================
  // suppression: set at power-up and on arming, left once off seen or when standby or the channel is disabled
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      standby_r <= 1'b1;
    else if (!stbyOn || !enable)
      standby_r <= 1'b0;
    else if (arm)
      standby_r <= 1'b1;
    else if (!rawCond)
      standby_r <= 1'b0;
  end

  // the arming edge suppresses at once, so no one-cycle pulse leaks out after halt release or a setpoint change
  assign qualified = rawCond && !(stbyOn && (standby_r || arm));
  assign standbyActive = standby_r;

  // ============================================================
  // output register: disabled, forced off when halted and the third digit is 1, then polarity
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      eventOut <= 1'b0;
    else if (!enable)
      eventOut <= 1'b0;
    else if (halted && haltDigit == DIG_ONE)
      eventOut <= 1'b0;
    else if (polDigit == DIG_ONE)
      eventOut <= !qualified;
    else
      eventOut <= qualified;
  end

endmodule
`default_nettype wire

// [ievt_top.sv]
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - each channel takes a type code 0..32; 0 disables; 1..15 are limit checks.
// - codes 7..9 check deviation against the final ramped setpoint.
// - codes 16..19 pick heater burnout and short, sensor one low pair.
// - codes 20..32 pick diagnoses and status sources; 26 and 31 invalid.
// - the option word is four decimal digits, first digit rightmost.
// - first digit picks polarity: 0 direct, 1 reverse.
// - second digit: 0 no standby, 1 standby, 2 standby plus setpoint re-arm.
// - third digit 1 forces the event off while halted.
// - standby holds the event off after halted-to-running; the power-up setting clears at once, as reset leaves the channel disabled.
// - suppression ends after the off condition is seen, or at once when standby or the channel is disabled.
// - mode 2 re-arms when the effective setpoint value changes; a group change alone does not re-arm.
// - no re-arm when the effective setpoint value stays the same.
module ievt_top
  import ievt_pkg::*;
(
  input wire logic clk_sys, // system clock, 50 MHz
  input wire logic rst, // async reset, high
  input wire logic [ievt_pkg::ADDR_W-1:0] regAddr, // register byte address
  input wire logic [ievt_pkg::DATA_W-1:0] regWrData, // write data
  input wire logic regWrStb, // write strobe
  input wire logic regRdStb, // read strobe
  output logic [ievt_pkg::DATA_W-1:0] regRdData, // read data, cycle after strobe
  input wire logic [ievt_pkg::NUM_CH-1:0][ievt_pkg::NUM_SRC-1:0] limHigh, // above high limit, per channel/source
  input wire logic [ievt_pkg::NUM_CH-1:0][ievt_pkg::NUM_SRC-1:0] limLow, // below low limit, per channel/source
  input wire logic [1:0] heaterBurnout, // burnout/over-current per current sensor
  input wire logic [1:0] heaterShort, // short-circuit per current sensor
  input wire logic [2:0] loopDiag, // loop diagnoses 1..3
  input wire logic alarmActive, // alarm status
  input wire logic haltedMode, // halted (not running)
  input wire logic manualMode, // manual mode
  input wire logic autoTuning, // auto tuning running
  input wire logic rampActive, // setpoint ramp running
  input wire logic directAction, // direct control action
  input wire logic selfTuning, // self tuning running
  input wire logic [ievt_pkg::NUM_CH-1:0] timerEvent, // timer status per channel
  input wire logic [ievt_pkg::SP_W-1:0] targetSetpoint, // effective setpoint value
  input wire logic [ievt_pkg::GRP_W-1:0] localSetpointGroup, // selected setpoint group
  output logic [ievt_pkg::NUM_CH-1:0] eventOut, // event outputs
  output logic irq // level interrupt
);

  // ============================================================
  // configuration registers
  logic [NUM_CH-1:0][CODE_W-1:0] typeCode_r;
  logic [NUM_CH-1:0][OPT_W-1:0] optWord_r;
  logic [NUM_CH-1:0] irqEn_r;
  logic [2*NUM_CH-1:0] irqStat_r;
  logic [NUM_CH-1:0] evPrev_r;
  logic [NUM_CH-1:0] standbyActive;
  logic [NUM_CH-1:0] rawCond;
  logic [NUM_CH-1:0] typeWrHit;
  logic [NUM_CH-1:0] optWrHit;
  logic haltedPrev_r;
  logic haltRelease;
  logic [SP_W-1:0] spPrev_r;
  logic spPrimed_r;
  logic spChanged;
  logic [DATA_W-1:0] rdNxt;
  logic [2*NUM_CH-1:0] irqSet;
  logic [2*NUM_CH-1:0] irqClr;

  genvar gi;

  generate
    for (gi = 0; gi < NUM_CH; gi = gi + 1)
    begin : g_wr
      assign typeWrHit[gi] = regWrStb && regAddr == (REG_TYPE_BASE + REG_CH_STRIDE * 8'(gi));
      assign optWrHit[gi] = regWrStb && regAddr == (REG_OPT_BASE + REG_CH_STRIDE * 8'(gi));

      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          typeCode_r[gi] <= TYPE_RST;
        else if (typeWrHit[gi])
          typeCode_r[gi] <= regWrData[CODE_W-1:0];
      end

      // four bcd digits, first digit in the low nibble
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          optWord_r[gi] <= OPT_RST;
        else if (optWrHit[gi])
          optWord_r[gi] <= regWrData[OPT_W-1:0];
      end
    end
  endgenerate

  // ============================================================
  // mode transition and setpoint change detection
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      haltedPrev_r <= 1'b0;
    else
      haltedPrev_r <= haltedMode;
  end

  assign haltRelease = haltedPrev_r && !haltedMode;

  // only the effective value is compared, so a group change that keeps the value is silent
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      spPrev_r <= '0;
      spPrimed_r <= 1'b0;
    end
    else
    begin
      spPrev_r <= targetSetpoint;
      spPrimed_r <= 1'b1;
    end
  end

  assign spChanged = spPrimed_r && (spPrev_r != targetSetpoint);

  // ============================================================
  // condition source selection per channel
  generate
    for (gi = 0; gi < NUM_CH; gi = gi + 1)
    begin : g_ch
      logic [CODE_W-1:0] idx;
      logic [2:0] src;
      logic [1:0] kind;

      // codes 1..15: source = (code-1)/3, kind 0 high 1 low 2 band
      assign idx = typeCode_r[gi] - 6'h01;
      assign src = 3'(idx / 6'h03);
      assign kind = 2'(idx % 6'h03);

      always_comb
      begin
        rawCond[gi] = 1'b0;
        if (typeCode_r[gi] != CODE_NONE && typeCode_r[gi] <= CODE_LIMIT_LAST)
        begin
          // source 2 carries the deviation against the final setpoint
          case (kind)
            2'd0: rawCond[gi] = limHigh[gi][src];
            2'd1: rawCond[gi] = limLow[gi][src];
            default: rawCond[gi] = limHigh[gi][src] || limLow[gi][src];
          endcase
        end
        else
        begin
          case (typeCode_r[gi])
            CODE_HEAT1_BURN: rawCond[gi] = heaterBurnout[0];
            CODE_HEAT1_SHORT: rawCond[gi] = heaterShort[0];
            CODE_HEAT2_BURN: rawCond[gi] = heaterBurnout[1];
            CODE_HEAT2_SHORT: rawCond[gi] = heaterShort[1];
            CODE_DIAG1: rawCond[gi] = loopDiag[0];
            CODE_DIAG2: rawCond[gi] = loopDiag[1];
            CODE_DIAG3: rawCond[gi] = loopDiag[2];
            CODE_ALARM: rawCond[gi] = alarmActive;
            CODE_HALTED: rawCond[gi] = haltedMode;
            CODE_MANUAL: rawCond[gi] = manualMode;
            CODE_AUTOTUNE: rawCond[gi] = autoTuning;
            CODE_RAMP: rawCond[gi] = rampActive;
            CODE_DIRECT: rawCond[gi] = directAction;
            CODE_SELFTUNE: rawCond[gi] = selfTuning;
            CODE_TIMER: rawCond[gi] = timerEvent[gi];
            // invalid codes never turn on before polarity
            CODE_INVALID_A: rawCond[gi] = 1'b0;
            CODE_INVALID_B: rawCond[gi] = 1'b0;
            default: rawCond[gi] = 1'b0;
          endcase
        end
      end

      // fourth digit is ignored
      ievt_qualify u_qual
      (
        .clk_sys(clk_sys),
        .rst(rst),
        .enable(typeCode_r[gi] != CODE_NONE && typeCode_r[gi] <= CODE_TIMER),
        .rawCond(rawCond[gi]),
        .polDigit(optWord_r[gi][DIG_POL_LSB +: 4]),
        .stbyDigit(optWord_r[gi][DIG_STBY_LSB +: 4]),
        .haltDigit(optWord_r[gi][DIG_HALT_LSB +: 4]),
        .halted(haltedMode),
        .haltRelease(haltRelease),
        .spChanged(spChanged),
        .eventOut(eventOut[gi]),
        .standbyActive(standbyActive[gi])
      );
    end
  endgenerate

  // ============================================================
  // interrupt: sticky edges of each event, set wins over clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      evPrev_r <= '0;
    else
      evPrev_r <= eventOut;
  end

  assign irqSet = {evPrev_r & ~eventOut, ~evPrev_r & eventOut};
  assign irqClr = (regWrStb && regAddr == REG_IRQ_CLR) ?
                  {regWrData[IRQ_FALL_LSB +: NUM_CH], regWrData[IRQ_RISE_LSB +: NUM_CH]} : '0;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irqStat_r <= '0;
    else
      irqStat_r <= irqSet | (irqStat_r & ~irqClr);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irqEn_r <= IRQ_EN_RST;
    else if (regWrStb && regAddr == REG_IRQ_EN)
      irqEn_r <= regWrData[NUM_CH-1:0];
  end

  // one enable bit covers both the rise and the fall of its channel
  assign irq = |(irqStat_r & {irqEn_r, irqEn_r});

  // ============================================================
  // register read, data one cycle after the strobe, unmapped reads zero
  always_comb
  begin
    rdNxt = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (regAddr == REG_TYPE_BASE + REG_CH_STRIDE * 8'(i))
        rdNxt[CODE_W-1:0] = typeCode_r[i];
      if (regAddr == REG_OPT_BASE + REG_CH_STRIDE * 8'(i))
        rdNxt[OPT_W-1:0] = optWord_r[i];
    end
    case (regAddr)
      REG_STATUS:
      begin
        rdNxt[STAT_EVT_LSB +: NUM_CH] = eventOut;
        rdNxt[STAT_STBY_LSB +: NUM_CH] = standbyActive;
        rdNxt[STAT_GRP_LSB +: GRP_W] = localSetpointGroup;
      end
      REG_IRQ_STAT:
      begin
        rdNxt[IRQ_RISE_LSB +: NUM_CH] = irqStat_r[NUM_CH-1:0];
        rdNxt[IRQ_FALL_LSB +: NUM_CH] = irqStat_r[2*NUM_CH-1:NUM_CH];
      end
      REG_IRQ_EN: rdNxt[NUM_CH-1:0] = irqEn_r;
      REG_SETPOINT: rdNxt[SP_W-1:0] = targetSetpoint;
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      regRdData <= '0;
    else if (regRdStb)
      regRdData <= rdNxt;
    else
      regRdData <= '0;
  end

endmodule
`default_nettype wire

// [ievt_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// port checks, channel 0 configuration shadowed from the bus
module ievt_chk
  import ievt_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, high
  input wire logic [ievt_pkg::ADDR_W-1:0] regAddr, // register address
  input wire logic [ievt_pkg::DATA_W-1:0] regWrData, // write data
  input wire logic regWrStb, // write strobe
  input wire logic regRdStb, // read strobe
  input wire logic [ievt_pkg::DATA_W-1:0] regRdData, // read data
  input wire logic [ievt_pkg::NUM_CH-1:0][ievt_pkg::NUM_SRC-1:0] limHigh, // high limit flags
  input wire logic [1:0] heaterBurnout, // burnout flags
  input wire logic haltedMode, // halted mode
  input wire logic [ievt_pkg::NUM_CH-1:0] eventOut, // event outputs
  input wire logic irq // level interrupt
);
  logic [CODE_W-1:0] type0_r;
  logic [OPT_W-1:0] opt0_r;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      type0_r <= TYPE_RST;
    else if (regWrStb && regAddr == REG_TYPE_BASE)
      type0_r <= regWrData[CODE_W-1:0];
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      opt0_r <= OPT_RST;
    else if (regWrStb && regAddr == REG_OPT_BASE)
      opt0_r <= regWrData[OPT_W-1:0];
  // ============================================================
  // assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence halt_exit_s;
    haltedMode ##1 (!haltedMode && limHigh[0][SRC_PV]);
  endsequence
  reset_quiet_a: assert property ($fell(rst) |-> eventOut == '0 && irq == 1'h0 && regRdData == '0)
    else $error("outputs not quiet after reset");
  rdata_idle_a: assert property (regRdData != '0 |-> $past(regRdStb))
    else $error("read data without a read strobe");
  irq_cause_a: assert property ($rose(irq) |-> $past(eventOut) != $past(eventOut, 2)
    || ($past(regWrStb) && $past(regAddr) == REG_IRQ_EN))
    else $error("interrupt rose without cause");
  code_off_a: assert property (type0_r == CODE_NONE |=> !eventOut[0])
    else $error("disabled channel drove its event");
  final_sp_a: assert property (type0_r == 6'h07 && opt0_r == OPT_RST |=> eventOut[0] == $past(limHigh[0][SRC_DEV_FINAL]))
    else $error("final setpoint deviation not followed");
  heater_map_a: assert property (type0_r == CODE_HEAT1_BURN && opt0_r == OPT_RST |=> eventOut[0] == $past(heaterBurnout[0]))
    else $error("sensor one burnout not followed");
  invalid_pol_a: assert property ((type0_r == CODE_INVALID_A || type0_r == CODE_INVALID_B)
    && !(haltedMode && opt0_r[11:8] == DIG_ONE) |=> eventOut[0] == ($past(opt0_r[3:0]) == DIG_ONE))
    else $error("invalid code output wrong");
  halt_force_a: assert property (haltedMode && opt0_r[11:8] == DIG_ONE |=> !eventOut[0])
    else $error("event not forced off while halted");
  halt_exit_a: assert property ((type0_r == 6'h01 && opt0_r == 16'h0010) throughout halt_exit_s |=> !eventOut[0])
    else $error("standby did not hold event off");
endmodule
bind ievt_top ievt_chk i_ievt_chk(.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .limHigh(limHigh),
  .heaterBurnout(heaterBurnout), .haltedMode(haltedMode), .eventOut(eventOut), .irq(irq));
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ievt_pkg::*;
  logic clk_sys, rst, regWrStb, regRdStb, irq, haltHold;
  logic alarmActive, haltedMode, manualMode, autoTuning, rampActive, directAction, selfTuning;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, d;
  logic [NUM_CH-1:0][NUM_SRC-1:0] limHigh, limLow;
  logic [1:0] heaterBurnout, heaterShort;
  logic [2:0] loopDiag;
  logic [NUM_CH-1:0] timerEvent, eventOut;
  logic [SP_W-1:0] targetSetpoint;
  logic [GRP_W-1:0] localSetpointGroup;
  int err_total, checks, cyc;
  ievt_top i_ievt_top(.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .limHigh(limHigh), .limLow(limLow),
    .heaterBurnout(heaterBurnout), .heaterShort(heaterShort), .loopDiag(loopDiag), .alarmActive(alarmActive),
    .haltedMode(haltedMode), .manualMode(manualMode), .autoTuning(autoTuning), .rampActive(rampActive),
    .directAction(directAction), .selfTuning(selfTuning), .timerEvent(timerEvent),
    .targetSetpoint(targetSetpoint), .localSetpointGroup(localSetpointGroup), .eventOut(eventOut), .irq(irq));
  initial
  begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ============================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regWrStb <= 1'h1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clk_sys);
    regWrStb <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    regRdStb <= 1'h1;
    regAddr <= a;
    @(posedge clk_sys);
    regRdStb <= 1'h0;
    #1;
    d = regRdData;
  endtask
  // drives the one source that the given code watches on channel 0
  task automatic drv(input int code, input logic v);
    logic [32:0] m;
    logic [NUM_SRC-1:0] hi, lo;
    m = '0;
    hi = '0;
    lo = '0;
    m[code] = v;
    if (code >= 1 && code <= 15)
      if ((code - 1) % 3 == 0)
        hi[(code - 1) / 3] = v;
      else
        lo[(code - 1) / 3] = v;
    @(posedge clk_sys);
    limHigh <= {20'h00000, hi};
    limLow <= {20'h00000, lo};
    heaterBurnout <= {m[18], m[16]};
    heaterShort <= {m[19], m[17]};
    loopDiag <= m[22:20];
    {alarmActive, haltedMode, manualMode} <= {m[23], m[24] | haltHold, m[25]};
    {selfTuning, directAction, rampActive, autoTuning} <= m[30:27];
    timerEvent <= {4'h0, m[32]};
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ============================================================
  // scenarios
  task automatic t_irq();
    rd(REG_TYPE_BASE);
    check(d, 32'h0);
    rd(REG_IRQ_EN);
    check(d, 32'h0);
    rd(8'h3c);
    check(d, 32'h0);
    wr(REG_TYPE_BASE, 32'h1);
    wr(REG_IRQ_EN, 32'h1);
    drv(1, 1'h1);
    tick(3);
    check(irq, 1'h1);
    rd(REG_IRQ_STAT);
    check(d, 32'h1);
    wr(REG_IRQ_CLR, 32'h1);
    tick(1);
    check(irq, 1'h0);
    drv(1, 1'h0);
    tick(3);
    check(irq, 1'h1);
    wr(REG_IRQ_EN, 32'h0);
    tick(1);
    check(irq, 1'h0);
    rd(REG_IRQ_STAT);
    check(d, 32'h100);
    rd(REG_STATUS);
    check(d & 32'h000f001f, 32'h00050000);
    $display("interrupt test done");
  endtask
  task automatic t_chan();
    wr(REG_TYPE_BASE + 8'h20, 32'h20);
    @(posedge clk_sys);
    timerEvent <= 5'h10;
    tick(2);
    check(eventOut, 5'h10);
    rd(REG_STATUS);
    check(d & 32'h1f, 32'h10);
    @(posedge clk_sys);
    timerEvent <= 5'h00;
    tick(2);
    check(eventOut, 5'h00);
    wr(REG_TYPE_BASE + 8'h20, 32'h0);
    $display("channel test done");
  endtask
  task automatic t_codes();
    logic exp;
    wr(REG_OPT_BASE, 32'h0);
    for (int c = 0; c <= 32; c++)
    begin
      wr(REG_TYPE_BASE, c);
      exp = !(c == 0 || c == 26 || c == 31);
      drv(c, 1'h1);
      tick(2);
      check(eventOut[0], exp);
      drv(c, 1'h0);
      tick(2);
      check(eventOut[0], 1'h0);
    end
    $display("code test done");
  endtask
  task automatic t_pol();
    wr(REG_TYPE_BASE, 32'h1);
    wr(REG_OPT_BASE, 32'h1);
    drv(1, 1'h0);
    tick(2);
    check(eventOut[0], 1'h1);
    drv(1, 1'h1);
    tick(2);
    check(eventOut[0], 1'h0);
    drv(24, 1'h1);
    tick(2);
    check(eventOut[0], 1'h1);
    wr(REG_OPT_BASE, 32'h0101);
    tick(2);
    check(eventOut[0], 1'h0);
    drv(0, 1'h0);
    tick(2);
    check(eventOut[0], 1'h1);
    wr(REG_TYPE_BASE, 32'h1a);
    tick(2);
    check(eventOut[0], 1'h1);
    wr(REG_TYPE_BASE, 32'h1);
    $display("polarity test done");
  endtask
  task automatic t_stby();
    wr(REG_OPT_BASE, 32'h0010);
    drv(1, 1'h0);
    drv(1, 1'h1);
    tick(2);
    check(eventOut[0], 1'h1);
    haltHold = 1'h1;
    drv(1, 1'h1);
    tick(3);
    haltHold = 1'h0;
    drv(1, 1'h1);
    tick(1);
    check(eventOut[0], 1'h0);
    tick(1);
    check(eventOut[0], 1'h0);
    tick(3);
    check(eventOut[0], 1'h0);
    drv(1, 1'h0);
    drv(1, 1'h1);
    tick(2);
    check(eventOut[0], 1'h1);
    @(posedge clk_sys);
    targetSetpoint <= 16'h0100;
    tick(3);
    check(eventOut[0], 1'h1);
    wr(REG_OPT_BASE, 32'h0020);
    @(posedge clk_sys);
    targetSetpoint <= 16'h0200;
    tick(1);
    check(eventOut[0], 1'h0);
    tick(1);
    check(eventOut[0], 1'h0);
    drv(1, 1'h0);
    drv(1, 1'h1);
    tick(2);
    check(eventOut[0], 1'h1);
    @(posedge clk_sys);
    localSetpointGroup <= 4'h3;
    tick(3);
    check(eventOut[0], 1'h1);
    $display("standby test done");
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end
  initial
  begin
    {rst, haltHold, regWrStb, regRdStb, regAddr, regWrData} = {1'h1, 43'h0};
    {limHigh, limLow, heaterBurnout, heaterShort, loopDiag, timerEvent} = '0;
    {alarmActive, haltedMode, manualMode, autoTuning, rampActive, directAction, selfTuning} = 7'h00;
    targetSetpoint = 16'h0000;
    localSetpointGroup = 4'h5;
    repeat (8) @(posedge clk_sys);
    rst <= 1'h0;
    t_irq();
    t_chan();
    t_codes();
    t_pol();
    t_stby();
    wrap_up();
  end
endmodule
`default_nettype wire
